// ==== design/dcc_defines.svh ====
// Register offsets, field positions, reset values for the dual comparator control block
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
`define DCC_OFS_STATUS     12'h000
`define DCC_OFS_CONTROL    12'h004
`define DCC_OFS_CMP_A      12'h008
`define DCC_OFS_ROUTE      12'h00C
`define DCC_BIT_RESULT     7
`define DCC_BIT_CALIB      6
`define DCC_BIT_REFSEL     5
`define DCC_TRIM_HI        4
`define DCC_BIT_EDGE_HI    7
`define DCC_BIT_EDGE_LO    6
`define DCC_BIT_IRQEN      3
`define DCC_BIT_PINOUT     2
`define DCC_BIT_POSSEL     1
`define DCC_BIT_ENABLE     0
`define DCC_BIT_SHARED     7
`define DCC_BIT_NEGSEL     1
`define DCC_BIT_OPA_A      0
`define DCC_BIT_OPA_B      1
`define DCC_TRIM_RESET     5'h10
`define DCC_CTRL_RESET     8'h02
`define DCC_CMPA_RESET     8'h82
`define DCC_RESP_OKAY      2'h0
`define DCC_RESP_SLVERR    2'h2
`endif

// ==== design/dcc_pkg.sv ====
// Types shared by the dual comparator control block
package dcc_pkg;
  typedef enum logic [1:0] {
    DCC_EDGE_NONE = 2'h0,
    DCC_EDGE_RISE = 2'h1,
    DCC_EDGE_FALL = 2'h2,
    DCC_EDGE_BOTH = 2'h3
  } dcc_edge_t;

  typedef enum logic [1:0] {
    DCC_WR_IDLE = 2'h1,
    DCC_WR_RESP = 2'h2
  } dcc_wr_state_t;

  // Pin function decode for the first comparator's shared pins
  typedef struct packed {
    logic negPinIsInput;
    logic sharedPinIsInput;
    logic outPinDriven;
  } dcc_pinmap_t;

  // Analog switch controls
  typedef struct packed {
    logic sharedPinSwitch;
    logic cmpBPinSwitch;
    logic cmpAPinSwitch;
    logic opampARouteSwitch;
    logic opampBRouteSwitch;
  } dcc_switch_t;
endpackage : dcc_pkg

// ==== design/dcc_control.sv ====
// Dual comparator control logic with AXI4-Lite register slave
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`include "dcc_defines.svh"

module dcc_control
  import dcc_pkg::*;
#(
  parameter bit HAS_CALIB = 1'b1
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // AXI4-Lite write address, data and response
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog comparator results
  input  wire logic        cmpARaw,
  input  wire logic        cmpBRaw,
  // Analog side controls
  output logic             cmpAEnableOut,
  output logic             cmpBEnableOut,
  output logic [4:0]       cmpATrimOut,
  output logic [4:0]       cmpBTrimOut,
  output logic             cmpBNegFromOpamp,
  output dcc_switch_t      switches,
  output dcc_pinmap_t      pinMap,
  output logic             cmpAOutPin,
  output logic             cmpBOutPinDriven,
  output logic             cmpBOutPin,
  output logic             cmpBIrqPulse
);

  // Storage
  logic        calibBReg;
  logic        refSelBReg;
  logic [4:0]  trimBReg;
  logic [7:0]  controlReg;
  logic [7:0]  cmpAReg;
  logic        calibAReg;
  logic        refSelAReg;
  logic [4:0]  trimAReg;
  logic [1:0]  opampRouteReg;
  logic [1:0]  syncA;
  logic [1:0]  syncB;
  logic        resultAReg;
  logic        resultBReg;
  dcc_wr_state_t wrState;
  logic        awHeld;
  logic        wHeld;
  logic [11:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0]  wStrbReg;

  // Effective select bits after hardware forcing
  logic calibAEff;
  logic calibBEff;
  logic sharedEff;
  logic negAEff;
  logic posBEff;
  logic opampAEff;
  logic opampBEff;
  logic cmpAEn;
  logic cmpBEn;
  dcc_edge_t edgeSel;

  assign cmpAEn    = cmpAReg[`DCC_BIT_ENABLE];
  assign cmpBEn    = controlReg[`DCC_BIT_ENABLE];
  assign edgeSel   = dcc_edge_t'(controlReg[`DCC_BIT_EDGE_HI:`DCC_BIT_EDGE_LO]);
  assign calibAEff = HAS_CALIB & calibAReg;
  assign calibBEff = HAS_CALIB & calibBReg;
  assign sharedEff = cmpAReg[`DCC_BIT_SHARED] | calibAEff | calibBEff;
  assign negAEff   = cmpAReg[`DCC_BIT_NEGSEL] | calibAEff;
  assign posBEff   = controlReg[`DCC_BIT_POSSEL] | calibBEff;
  assign opampAEff = opampRouteReg[0] & ~sharedEff;
  assign opampBEff = opampRouteReg[1] & ~sharedEff & ~opampRouteReg[0];

  // Write channel handshake and register updates
  logic        wrFire;
  logic [31:0] wrData;
  assign wrFire = awHeld & wHeld & (wrState == DCC_WR_IDLE);
  assign wrData = wDataReg;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      awHeld    <= 1'b0;
      wHeld     <= 1'b0;
      awAddrReg <= 12'h000;
      wDataReg  <= 32'h0000_0000;
      wStrbReg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld    <= 1'b1;
        awAddrReg <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld    <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~awHeld & (wrState == DCC_WR_IDLE);
  assign s_axi_wready  = ~wHeld & (wrState == DCC_WR_IDLE);

  // Response state machine
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrState      <= DCC_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DCC_RESP_OKAY;
    end else begin
      case (wrState)
        DCC_WR_IDLE: begin
          if (wrFire) begin
            wrState      <= DCC_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddrReg[11:4] == 8'h00) ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
          end
        end
        DCC_WR_RESP: begin
          if (s_axi_bready) begin
            wrState      <= DCC_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wrState      <= DCC_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Register file; writes need the byte lane 0 strobe, which also gates the comparator A trim in 12:8
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      calibBReg     <= 1'b0;
      refSelBReg    <= 1'b0;
      trimBReg      <= `DCC_TRIM_RESET;
      controlReg    <= `DCC_CTRL_RESET;
      cmpAReg       <= `DCC_CMPA_RESET;
      calibAReg     <= 1'b0;
      refSelAReg    <= 1'b0;
      trimAReg      <= `DCC_TRIM_RESET;
      opampRouteReg <= 2'h0;
    end else if (wrFire && wStrbReg[0]) begin
      case (awAddrReg)
        `DCC_OFS_STATUS: begin
          if (HAS_CALIB) begin
            calibBReg  <= wrData[`DCC_BIT_CALIB];
            refSelBReg <= wrData[`DCC_BIT_REFSEL];
            trimBReg   <= wrData[`DCC_TRIM_HI:0];
          end
        end
        `DCC_OFS_CONTROL: controlReg <= {wrData[7:6], 2'h0, wrData[3:0]};
        `DCC_OFS_CMP_A: begin
          cmpAReg    <= {wrData[7], 3'h0, wrData[3:0]};
          calibAReg  <= HAS_CALIB & wrData[`DCC_BIT_CALIB];
          refSelAReg <= wrData[`DCC_BIT_REFSEL];
          trimAReg   <= wrData[12:8];
        end
        `DCC_OFS_ROUTE: opampRouteReg <= wrData[1:0];
        default: ;
      endcase
    end
  end

  // Read channel
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (s_axi_araddr)
      `DCC_OFS_STATUS: rdMux[7:0] = HAS_CALIB
          ? {resultBReg, calibBReg, refSelBReg, trimBReg}
          : {resultBReg, 7'h00};
      `DCC_OFS_CONTROL: rdMux[7:0] = {controlReg[7:6], 2'h0, controlReg[3:2],
                                      posBEff, controlReg[0]};
      // Comparator A word: trim in 12:8, shared select on top of the low byte
      `DCC_OFS_CMP_A: rdMux = {19'h0, trimAReg, sharedEff, calibAReg, refSelAReg,
                               resultAReg, cmpAReg[3:2], negAEff, cmpAReg[0]};
      `DCC_OFS_ROUTE: rdMux[1:0] = {opampBEff, opampAEff};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DCC_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= (s_axi_araddr[11:4] == 8'h00) ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;

  // Result synchronisers and gated result flags
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      syncA      <= 2'h0;
      syncB      <= 2'h0;
      resultAReg <= 1'b0;
      resultBReg <= 1'b0;
    end else begin
      syncA      <= {syncA[0], cmpARaw};
      syncB      <= {syncB[0], cmpBRaw};
      resultAReg <= syncA[1] & cmpAEn;
      resultBReg <= syncB[1] & cmpBEn;
    end
  end

  // Edge detection on comparator B result
  logic riseB;
  logic fallB;
  logic edgeHit;
  assign riseB = cmpBEn & syncB[1] & ~resultBReg;
  assign fallB = cmpBEn & ~syncB[1] & resultBReg;
  always_comb begin
    case (edgeSel)
      DCC_EDGE_RISE: edgeHit = riseB;
      DCC_EDGE_FALL: edgeHit = fallB;
      DCC_EDGE_BOTH: edgeHit = riseB | fallB;
      default:       edgeHit = 1'b0;
    endcase
  end

  // Analog controls and pin decode, all registered
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cmpBIrqPulse     <= 1'b0;
      cmpAEnableOut    <= 1'b0;
      cmpBEnableOut    <= 1'b0;
      cmpATrimOut      <= `DCC_TRIM_RESET;
      cmpBTrimOut      <= `DCC_TRIM_RESET;
      cmpBNegFromOpamp <= 1'b0;
      switches         <= '0;
      pinMap           <= '0;
      cmpAOutPin       <= 1'b0;
      cmpBOutPinDriven <= 1'b0;
      cmpBOutPin       <= 1'b0;
    end else begin
      cmpBIrqPulse     <= edgeHit & controlReg[`DCC_BIT_IRQEN];
      cmpAEnableOut    <= cmpAEn;
      cmpBEnableOut    <= cmpBEn;
      cmpATrimOut      <= trimAReg;
      cmpBTrimOut      <= trimBReg;
      cmpBNegFromOpamp <= ~sharedEff;
      switches.sharedPinSwitch   <= sharedEff;
      switches.cmpBPinSwitch     <= posBEff;
      switches.cmpAPinSwitch     <= negAEff;
      switches.opampARouteSwitch <= opampAEff;
      switches.opampBRouteSwitch <= opampBEff;
      pinMap.negPinIsInput    <= cmpAEn & negAEff;
      pinMap.sharedPinIsInput <= cmpAEn & sharedEff;
      pinMap.outPinDriven     <= cmpAEn & cmpAReg[`DCC_BIT_PINOUT];
      cmpAOutPin       <= resultAReg;
      cmpBOutPinDriven <= cmpBEn & controlReg[`DCC_BIT_PINOUT];
      cmpBOutPin       <= resultBReg;
    end
  end

  // Checks, watched on the registered interrupt pulse, comparator B result flag, switch and pin outputs
  chk_irq_on_rise: assert property (@(posedge mclk) disable iff (!reset_n)
    riseB && controlReg[3] && edgeSel == DCC_EDGE_RISE |=> cmpBIrqPulse)
    else $error("rising edge did not raise the interrupt");
  chk_irq_needs_en: assert property (@(posedge mclk) disable iff (!reset_n)
    cmpBIrqPulse |-> $past(controlReg[3]) && $past(edgeHit))
    else $error("interrupt raised while disabled");
  chk_disabled_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    !cmpBEn |=> !resultBReg)
    else $error("disabled comparator shows a result");
  chk_calib_forces: assert property (@(posedge mclk) disable iff (!reset_n)
    calibBEff |=> switches.sharedPinSwitch && switches.cmpBPinSwitch)
    else $error("calibration did not force selects");
  chk_calib_a_force: assert property (@(posedge mclk) disable iff (!reset_n)
    calibAEff |=> switches.sharedPinSwitch && switches.cmpAPinSwitch)
    else $error("calibration A did not force selects");
  chk_opamp_excl: assert property (@(posedge mclk) disable iff (!reset_n)
    !(switches.opampARouteSwitch && switches.opampBRouteSwitch) &&
    !(switches.sharedPinSwitch && (switches.opampARouteSwitch || switches.opampBRouteSwitch)))
    else $error("op-amp routes not exclusive");
  chk_shared_opens: assert property (@(posedge mclk) disable iff (!reset_n)
    sharedEff |=> !switches.opampARouteSwitch && !switches.opampBRouteSwitch)
    else $error("shared select left op-amp route closed");
  chk_pin_out: assert property (@(posedge mclk) disable iff (!reset_n)
    !cmpAEn |=> !pinMap.outPinDriven && !pinMap.negPinIsInput)
    else $error("disabled comparator claimed a pin");

endmodule // dcc_control

// ==== test/dcc_analog_model.sv ====
// Behavioural model of the two analog comparators
module dcc_analog_model #(
  parameter logic [4:0] TRIP = 5'h18
) (
  // Clock
  input  wire logic       mclk,
  // Controls from the block and the bench
  input  wire logic       enA,
  input  wire logic       enB,
  input  wire logic [4:0] trimB,
  input  wire logic       levelA,
  input  wire logic       levelB,
  // Comparator results
  output logic            rawA,
  output logic            rawB
);
  timeunit 1ns;
  timeprecision 1ps;
  logic toggle = 1'h0;
  // A powered-down comparator gives no stable level
  always @(posedge mclk) begin
    toggle <= ~toggle;
  end
  // Trim at or above the trip point flips comparator B
  assign rawA = enA ? levelA : ~toggle;
  assign rawB = enB ? (levelB | (trimB >= TRIP)) : toggle;
endmodule // dcc_analog_model

// ==== test/tb.sv ====
// Self-checking testbench for the dual comparator control block
module tb
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0, reset_n = 1'h0, levelA = 1'h0, levelB = 1'h0;
  logic [11:0] awAddr = 12'h0, arAddr = 12'h0;
  logic [31:0] wData = 32'h0, rdv;
  logic [3:0] wStrb = 4'hF;
  logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
  logic awReady, wReady, bValid, arReady, rValid, rawA, rawB, enA, enB;
  logic negOp, aOut, bDrv, bOut, bIrq;
  logic [1:0] bResp, rResp, rsp;
  logic [31:0] rData;
  logic [31:0] rDataBasic, rdBasic;
  logic [4:0] trimA, trimB;
  dcc_switch_t sw;
  dcc_pinmap_t pm;
  int mismatches = 0, cmpCount = 0, cycles = 0, pulses = 0, p0;

  dcc_control uut (
    .mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .cmpARaw(rawA), .cmpBRaw(rawB), .cmpAEnableOut(enA), .cmpBEnableOut(enB),
    .cmpATrimOut(trimA), .cmpBTrimOut(trimB), .cmpBNegFromOpamp(negOp),
    .switches(sw), .pinMap(pm), .cmpAOutPin(aOut), .cmpBOutPinDriven(bDrv),
    .cmpBOutPin(bOut), .cmpBIrqPulse(bIrq));

  dcc_analog_model model (.mclk(mclk), .enA(enA), .enB(enB), .trimB(trimB),
    .levelA(levelA), .levelB(levelB), .rawA(rawA), .rawB(rawB));

  // Variant without calibration, fed from the same bus
  dcc_control #(.HAS_CALIB(1'b0)) uutBasic (
    .mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(), .s_axi_rdata(rDataBasic), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready(rReady), .cmpARaw(rawA), .cmpBRaw(rawB), .cmpAEnableOut(),
    .cmpBEnableOut(), .cmpATrimOut(), .cmpBTrimOut(), .cmpBNegFromOpamp(),
    .switches(), .pinMap(), .cmpAOutPin(), .cmpBOutPinDriven(), .cmpBOutPin(),
    .cmpBIrqPulse());

  always #20 mclk = ~mclk;
  // Cycle ceiling and interrupt pulse count
  always @(posedge mclk) begin
    cycles++;
    if (bIrq === 1'h1) pulses++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One AXI4-Lite write, response code compared
  task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'h1;
    wValid <= 1'h1;
    bReady <= 1'h1;
    do begin
      @(posedge mclk);
      if (awValid && awReady === 1'h1) awValid <= 1'h0;
      if (wValid && wReady === 1'h1) wValid <= 1'h0;
    end while (bValid !== 1'h1);
    bReady <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, bResp});
  endtask

  // One AXI4-Lite read into rdv and rsp
  task automatic axiRd(input logic [11:0] a);
    @(posedge mclk);
    arAddr <= a;
    arValid <= 1'h1;
    rReady <= 1'h1;
    do begin
      @(posedge mclk);
      if (arValid && arReady === 1'h1) arValid <= 1'h0;
    end while (rValid !== 1'h1);
    rReady <= 1'h0;
    rdv = rData;
    rdBasic = rDataBasic;
    rsp = rResp;
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] e, input string nm);
    axiRd(a);
    chk(nm, e, rdv);
  endtask

  task automatic testReset();
    rdChk(12'h000, 32'h10, "status");
    rdChk(12'h004, 32'h02, "control");
    rdChk(12'h008, 32'h1082, "cmpA");
    rdChk(12'h00C, 32'h0, "route");
    chk("trimA", 32'h10, {27'h0, trimA});
    $display("test reset done");
  endtask

  task automatic testFields();
    axiWr(12'h004, 32'hFF, 2'h0);
    rdChk(12'h004, 32'hCF, "ctrlUnused");
    chk("enB", 32'h1, {31'h0, enB});
    axiWr(12'h004, 32'h00, 2'h0);
    axiWr(12'h000, 32'hFF, 2'h0);
    rdChk(12'h000, 32'h7F, "statusRo");
    chk("basicStatus", 32'h0, rdBasic);
    axiWr(12'h000, 32'h10, 2'h0);
    axiWr(12'h100, 32'hFF, 2'h2);
    axiRd(12'h100);
    chk("rresp", 32'h2, {30'h0, rsp});
    rdChk(12'h000, 32'h10, "noEffect");
    $display("test fields done");
  endtask

  task automatic testCalib();
    axiWr(12'h008, 32'h1000, 2'h0);
    axiWr(12'h000, 32'h50, 2'h0);
    rdChk(12'h008, 32'h1080, "sharedForced");
    rdChk(12'h004, 32'h02, "posForced");
    chk("pinSw", 32'h3, {30'h0, sw.sharedPinSwitch, sw.cmpBPinSwitch});
    axiWr(12'h000, 32'h10, 2'h0);
    rdChk(12'h008, 32'h1000, "sharedBack");
    rdChk(12'h004, 32'h00, "posBack");
    axiWr(12'h008, 32'h1040, 2'h0);
    rdChk(12'h008, 32'h10C2, "aForced");
    chk("aPinSw", 32'h3, {30'h0, sw.sharedPinSwitch, sw.cmpAPinSwitch});
    axiWr(12'h008, 32'h1000, 2'h0);
    rdChk(12'h008, 32'h1000, "aBack");
    $display("test calibration force done");
  endtask

  task automatic testRoute();
    axiWr(12'h00C, 32'h3, 2'h0);
    rdChk(12'h00C, 32'h1, "onlyOneOpamp");
    chk("opSw", 32'h2, {30'h0, sw.opampARouteSwitch, sw.opampBRouteSwitch});
    axiWr(12'h00C, 32'h2, 2'h0);
    rdChk(12'h00C, 32'h2, "opampB");
    chk("negOp", 32'h1, {31'h0, negOp});
    axiWr(12'h008, 32'h1080, 2'h0);
    rdChk(12'h00C, 32'h0, "sharedOff");
    chk("opSwOff", 32'h0, {30'h0, sw.opampARouteSwitch, sw.opampBRouteSwitch});
    $display("test routing done");
  endtask

  task automatic testPins();
    chk("pinsOff", 32'h0, {29'h0, pm});
    axiWr(12'h008, 32'h1087, 2'h0);
    levelA <= 1'h1;
    repeat (8) @(posedge mclk);
    chk("pinsOn", 32'h7, {29'h0, pm});
    chk("aOut", 32'h1, {31'h0, aOut});
    chk("enA", 32'h1, {31'h0, enA});
    rdChk(12'h008, 32'h1097, "resultA");
    axiWr(12'h008, 32'h1001, 2'h0);
    repeat (2) @(posedge mclk);
    chk("pinsGpio", 32'h0, {29'h0, pm});
    axiWr(12'h008, 32'h1080, 2'h0);
    levelA <= 1'h0;
    $display("test pins done");
  endtask

  // Every edge code, plus both edges with the interrupt masked
  task automatic testEdges();
    logic [1:0] code;
    logic irq;
    for (int i = 0; i < 5; i++) begin
      code = (i < 4) ? i[1:0] : 2'h3;
      irq = (i < 4);
      axiWr(12'h004, {24'h0, code, 2'h0, irq, 3'h7}, 2'h0);
      repeat (8) @(posedge mclk);
      p0 = pulses;
      levelB <= 1'h1;
      repeat (8) @(posedge mclk);
      chk("risePulses", {31'h0, code[0] & irq}, pulses - p0);
      chk("bPin", 32'h3, {30'h0, bDrv, bOut});
      rdChk(12'h000, 32'h90, "resultB");
      chk("basicResult", 32'h80, rdBasic);
      p0 = pulses;
      levelB <= 1'h0;
      repeat (8) @(posedge mclk);
      chk("fallPulses", {31'h0, code[1] & irq}, pulses - p0);
    end
    $display("test edges done");
  endtask

  task automatic testDisabled();
    axiWr(12'h004, 32'hC8, 2'h0);
    p0 = pulses;
    repeat (20) @(posedge mclk);
    chk("offPulses", 32'h0, pulses - p0);
    rdChk(12'h000, 32'h10, "offResult");
    $display("test disabled done");
  endtask

  // Calibration sweep in the software order
  task automatic testSweep();
    logic [4:0] trip;
    trip = 5'h0;
    axiWr(12'h004, 32'h03, 2'h0);
    for (int t = 16; t < 32; t++) begin
      axiWr(12'h000, 32'h60 | t, 2'h0);
      repeat (6) @(posedge mclk);
      axiRd(12'h000);
      trip = t[4:0];
      if (rdv[7] === 1'h1) break;
    end
    chk("tripTrim", 32'h18, {27'h0, trip});
    chk("trimB", 32'h18, {27'h0, trimB});
    axiWr(12'h000, 32'h18, 2'h0);
    rdChk(12'h000, 32'h98, "normalMode");
    $display("test sweep done");
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'h1;
    testReset();
    testFields();
    testCalib();
    testRoute();
    testPins();
    testEdges();
    testDisabled();
    testSweep();
    tally_and_finish();
  end
endmodule // tb
